// file: hw/flash_read_pkg.sv
// constants, types and field layout for the flash burst read control
// Notes on behaviour
// - mode bit one: async page; zero: burst
// - first word after latency count valid edges
// - no wait states inside one word line
// - polarity bit sets asserted level of stall
// - burst mode: stall output changes on valid edges only
// - burst mode: stall asserted until data valid
// - non-array reads use same stall behaviour
// - non-array line end: first access only
// - async reads hold stall at deasserted level
// - stall floats unless chip and output enabled
// - hold bit: two clocks per word, else one
// - early release bit: release one data cycle early
// - linear order only; order bit kept one
// - size field: 4, 8, 16 or continuous
// - wrap mode counts modulo length in group
// - no-wrap mode counts straight across groups
// - continuous bursts always count straight up
// - edge bit picks rising or falling bus edge
// - first row crossing may add up to latency-1 stalls
package flash_read_pkg;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // read_config_reg reset: async, latency 7, all option bits set, continuous
  localparam logic [15:0] CFG_RESET = 16'hBFCF;

  // burst_size encodings
  localparam logic [2:0] SIZE_4 = 3'h1;
  localparam logic [2:0] SIZE_8 = 3'h2;
  localparam logic [2:0] SIZE_16 = 3'h3;
  localparam logic [2:0] SIZE_CONT = 3'h7;

  // masks of the low address bits that wrap for each size
  localparam logic [3:0] MASK_4 = 4'h3;
  localparam logic [3:0] MASK_8 = 4'h7;
  localparam logic [3:0] MASK_16 = 4'hF;

  // lowest latency code the logic serves
  localparam logic [2:0] LATENCY_MIN = 3'h2;
  // last word index in a device row, and words per row group
  localparam logic [3:0] ROW_LAST = 4'hF;
  localparam logic [2:0] ROW_GROUP = 3'h4;

  typedef struct packed {
    logic read_mode_select;     // 15
    logic rsvd_14;              // 14
    logic [2:0] first_access_latency; // 13:11
    logic wait_polarity;        // 10
    logic data_hold_cycles;     // 9
    logic stall_early_release;  // 8
    logic burst_order;          // 7
    logic clk_rising;           // 6
    logic [1:0] rsvd_5_4;       // 5:4
    logic burst_nowrap;         // 3
    logic [2:0] burst_size;     // 2:0
  } read_config_t;

  typedef struct packed {
    logic bus_clk;
    logic chip_en_n;
    logic out_en_n;
    logic address_valid_n;
    logic nonarray;
  } flash_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LATENCY = 3'b001,
    ST_DATA = 3'b011,
    ST_ROW_STALL = 3'b010,
    ST_DONE = 3'b110
  } burst_state_t;

endpackage

// file: hw/flash_burst_read.sv
// flash read-side control: async page reads, synchronous bursts, stall output
`timescale 1ns/1ps
`default_nettype none
module flash_burst_read #(
  parameter int ADDR_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash bus pins
  input wire flash_read_pkg::flash_ctrl_t ctrl_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic wait_o,
  output logic wait_oe_o,
  // array read port
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [15:0] mem_data_i
);

  initial begin
    if (ADDR_W < 5 || ADDR_W > 30) begin
      $error("ADDR_W must lie in 5..30");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  flash_read_pkg::read_config_t cfg;
  flash_read_pkg::burst_state_t state;
  flash_read_pkg::burst_state_t next_state;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [4:0] words;
  logic row_crossed;
  logic nonarray_q;
  logic wb_hit;
  logic wb_write;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_write = wb_hit & wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= flash_read_pkg::CFG_RESET;
    end else if (wb_write && wb_adr_i == flash_read_pkg::CFG_OFFSET) begin
      if (wb_sel_i[0]) begin
        cfg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        cfg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      if (wb_adr_i == flash_read_pkg::CFG_OFFSET) begin
        wb_dat_o <= {16'h0000, cfg};
      end else if (wb_adr_i == flash_read_pkg::STATUS_OFFSET) begin
        wb_dat_o <= {state, words, row_crossed, nonarray_q, 22'(cur_addr)};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus clock edge select and cycle qualifiers

  logic bus_clk_q;
  logic edge_en;
  logic active;
  logic sync_mode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_clk_q <= 1'b0;
    end else begin
      bus_clk_q <= ctrl_i.bus_clk;
    end
  end

  // edge bit chooses which bus clock transition is the valid edge
  assign edge_en = cfg.clk_rising ? (ctrl_i.bus_clk & ~bus_clk_q)
                                  : (~ctrl_i.bus_clk & bus_clk_q);
  assign active = ~ctrl_i.chip_en_n & ~ctrl_i.out_en_n;
  assign sync_mode = ~cfg.read_mode_select;

  ////////////////////////////////////////////////////////////////////////////
  // burst geometry

  logic [3:0] wrap_mask;
  logic continuous;
  logic [4:0] burst_len;
  logic [1:0] hold_len;
  logic [2:0] to_valid;
  logic [2:0] stall_left;
  logic [2:0] next_to_valid;
  logic [2:0] next_stall_left;
  logic [1:0] hold_cnt;
  logic [1:0] next_hold_cnt;
  logic [2:0] row_stall;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] inc_addr;
  logic [3:0] early;

  // only the linear order exists; the order bit does not change sequencing
  always_comb begin
    continuous = 1'b0;
    wrap_mask = flash_read_pkg::MASK_16;
    burst_len = 5'h10;
    case (cfg.burst_size)
      flash_read_pkg::SIZE_4: begin
        wrap_mask = flash_read_pkg::MASK_4;
        burst_len = 5'h04;
      end
      flash_read_pkg::SIZE_8: begin
        wrap_mask = flash_read_pkg::MASK_8;
        burst_len = 5'h08;
      end
      flash_read_pkg::SIZE_16: begin
        wrap_mask = flash_read_pkg::MASK_16;
        burst_len = 5'h10;
      end
      default: begin
        continuous = 1'b1;
      end
    endcase
  end

  assign hold_len = cfg.data_hold_cycles ? 2'd2 : 2'd1;
  assign inc_addr = cur_addr + ADDR_W'(1);

  // wrap inside the aligned group, or count straight up
  always_comb begin
    if (continuous || cfg.burst_nowrap) begin
      next_addr = inc_addr;
    end else begin
      next_addr = {cur_addr[ADDR_W-1:4],
                   (cur_addr[3:0] & ~wrap_mask) | (inc_addr[3:0] & wrap_mask)};
    end
  end

  // stalls at the first row crossing: offset in group plus latency minus four
  always_comb begin
    logic [3:0] sum;
    sum = {2'b00, start_addr[1:0]} + {1'b0, cfg.first_access_latency};
    if (sum > {1'b0, flash_read_pkg::ROW_GROUP}) begin
      row_stall = 3'(sum - {1'b0, flash_read_pkg::ROW_GROUP});
    end else begin
      row_stall = 3'd0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer, advanced on valid edges only

  logic start;
  logic load_word;

  assign start = edge_en & sync_mode & ~ctrl_i.chip_en_n & ~ctrl_i.address_valid_n;

  always_comb begin
    next_state = state;
    next_to_valid = to_valid;
    next_stall_left = stall_left;
    next_hold_cnt = hold_cnt;
    load_word = 1'b0;
    if (ctrl_i.chip_en_n || !sync_mode) begin
      next_state = flash_read_pkg::ST_IDLE;
    end else if (start) begin
      // latency counted from the last valid edge with the strobe low
      next_state = flash_read_pkg::ST_LATENCY;
      next_to_valid = cfg.first_access_latency - 3'd1;
    end else if (edge_en) begin
      case (state)
        flash_read_pkg::ST_LATENCY: begin
          if (to_valid <= 3'd1) begin
            next_state = flash_read_pkg::ST_DATA;
            next_hold_cnt = 2'd0;
            next_to_valid = 3'd0;
          end else begin
            next_to_valid = to_valid - 3'd1;
          end
        end
        flash_read_pkg::ST_DATA: begin
          if (hold_cnt + 2'd1 >= hold_len) begin
            next_hold_cnt = 2'd0;
            // one new word per data cycle until the size is reached
            if (!continuous && words + 5'd1 >= burst_len) begin
              next_state = flash_read_pkg::ST_DONE;
            end else begin
              load_word = 1'b1;
              // no stall inside a row; non-array reads only manage the first
              if (cur_addr[3:0] == flash_read_pkg::ROW_LAST && !row_crossed && !nonarray_q
                  && (continuous || cfg.burst_nowrap) && row_stall != 3'd0) begin
                next_state = flash_read_pkg::ST_ROW_STALL;
                next_stall_left = row_stall;
              end
            end
          end else begin
            next_hold_cnt = hold_cnt + 2'd1;
          end
        end
        flash_read_pkg::ST_ROW_STALL: begin
          if (stall_left <= 3'd1) begin
            next_state = flash_read_pkg::ST_DATA;
            next_stall_left = 3'd0;
          end else begin
            next_stall_left = stall_left - 3'd1;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= flash_read_pkg::ST_IDLE;
      to_valid <= 3'd0;
      stall_left <= 3'd0;
      hold_cnt <= 2'd0;
    end else begin
      state <= next_state;
      to_valid <= next_to_valid;
      stall_left <= next_stall_left;
      hold_cnt <= next_hold_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_addr <= '0;
      start_addr <= '0;
      words <= 5'd0;
      row_crossed <= 1'b0;
      nonarray_q <= 1'b0;
    end else if (start) begin
      cur_addr <= addr_i;
      start_addr <= addr_i;
      words <= 5'd0;
      row_crossed <= 1'b0;
      nonarray_q <= ctrl_i.nonarray;
    end else if (load_word) begin
      cur_addr <= next_addr;
      words <= words + 5'd1;
      if (cur_addr[3:0] == flash_read_pkg::ROW_LAST) begin
        row_crossed <= 1'b1;
      end
    end else if (!sync_mode) begin
      cur_addr <= addr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data path

  logic data_valid;

  assign mem_addr_o = cur_addr;
  assign data_valid = (state == flash_read_pkg::ST_DATA) || (state == flash_read_pkg::ST_DONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_o <= 16'h0000;
      dq_oe_o <= 1'b0;
    end else begin
      dq_oe_o <= active & (~sync_mode | data_valid);
      if (!sync_mode || state == flash_read_pkg::ST_DATA) begin
        dq_o <= mem_data_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stall output

  logic next_stall;
  logic stall_asserted;
  logic stall_edge_q;
  logic next_stall_q;

  // early release lets go one data cycle ahead of valid data
  assign early = cfg.stall_early_release ? {2'b00, hold_len} : 4'd0;

  // asserted until valid data, same for array and non-array reads
  always_comb begin
    case (next_state)
      flash_read_pkg::ST_LATENCY: begin
        next_stall = {1'b0, next_to_valid} > early;
      end
      flash_read_pkg::ST_ROW_STALL: begin
        next_stall = {1'b0, next_stall_left} > early;
      end
      default: begin
        next_stall = 1'b0;
      end
    endcase
  end

  // decision held one clock so the pin moves together with the registered data word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stall_edge_q <= 1'b0;
      next_stall_q <= 1'b0;
    end else begin
      stall_edge_q <= edge_en & active;
      next_stall_q <= next_stall;
    end
  end

  // updated one clock after a valid edge of an enabled read cycle; cleared on every clock in async mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stall_asserted <= 1'b0;
    end else if (!sync_mode) begin
      stall_asserted <= 1'b0;
    end else if (stall_edge_q) begin
      stall_asserted <= next_stall_q;
    end
  end

  assign wait_o = stall_asserted ? cfg.wait_polarity : ~cfg.wait_polarity;
  assign wait_oe_o = active;

endmodule
`default_nettype wire

// file: verification/flash_burst_read_checker.sv
// port assertions for the flash burst read control
`timescale 1ns/1ps
`default_nettype none
module flash_burst_read_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire flash_read_pkg::flash_ctrl_t ctrl_i,
  input wire logic [15:0] dq_o,
  input wire logic wait_o,
  input wire logic wait_oe_o,
  input wire logic [15:0] mem_data_i
);
  flash_read_pkg::read_config_t cfg;
  logic b1, ve, snc;
  always_ff @(posedge clk_i) begin
    if (rst_i) cfg <= flash_read_pkg::CFG_RESET;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00)
      cfg <= wb_dat_i[15:0];
  end
  always_ff @(posedge clk_i) begin
    b1 <= ctrl_i.bus_clk;
  end
  // valid bus edge in the sample where the design first sees it
  assign ve = ctrl_i.bus_clk != b1 && ctrl_i.bus_clk == cfg.clk_rising;
  assign snc = !cfg.read_mode_select && wait_oe_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_STALL_FLOAT: // float
    assert property (wait_oe_o == (!ctrl_i.chip_en_n && !ctrl_i.out_en_n))
    else $error("stall enable wrong");
  AST_ASYNC_IDLE: // async
    assert property (cfg.read_mode_select && $past(cfg.read_mode_select) |->
      wait_o == !cfg.wait_polarity) else $error("async stall asserted");
  AST_START_STALL: // start
    assert property (snc && !cfg.stall_early_release && ve && !ctrl_i.address_valid_n |->
      ##[1:3] wait_o == cfg.wait_polarity) else $error("no stall at burst start");
  AST_STALL_EDGE: // stall
    assert property ($changed(wait_o) && cfg == $past(cfg, 2) |->
      $past(wait_oe_o) && ($past(ve) || $past(ve, 2))) else $error("stall off edge");
  AST_DATA_EDGE: // data
    assert property (snc && $past(snc) && $changed(dq_o) && cfg == $past(cfg, 2) |->
      $past(ve) || $past(ve, 2)) else $error("data off edge");
  AST_HOLD_TWO: // hold
    assert property (snc && cfg.data_hold_cycles && $changed(dq_o) |=>
      ($stable(dq_o) || !wait_oe_o)[*7]) else $error("word held too short");
  AST_ASYNC_DATA: // async
    assert property (cfg.read_mode_select && $past(cfg.read_mode_select) && !$past(rst_i) |->
      dq_o == $past(mem_data_i)) else $error("async data not following array");
  AST_RELEASE_WITH_DATA: // release
    assert property (snc && !cfg.stall_early_release && $changed(wait_o) &&
      wait_o == !cfg.wait_polarity && cfg == $past(cfg, 2) |-> $changed(dq_o))
    else $error("stall released without data");
  COV_HOLD_TWO: cover property (snc && cfg.data_hold_cycles && $changed(dq_o));
  COV_RELEASE: cover property (snc && $changed(wait_o));
  COV_ASYNC: cover property (cfg.read_mode_select && wait_oe_o);
endmodule
bind flash_burst_read flash_burst_read_checker i_flash_burst_read_checker (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .ctrl_i, .dq_o, .wait_o,
  .wait_oe_o, .mem_data_i);
`default_nettype wire

// file: verification/flash_host_model.sv
// host controller and array model facing the flash read control
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic stop_i,
  input wire logic [23:0] start_i,
  input wire logic [15:0] salt_i,
  input wire logic [23:0] mem_addr_i,
  output var flash_read_pkg::flash_ctrl_t ctrl_o,
  output logic [23:0] addr_o,
  output logic [15:0] mem_data_o
);
  logic [3:0] cnt;
  initial begin
    ctrl_o = 5'b01110;
    addr_o = 24'h00_0000;
    cnt = 4'h0;
  end
  assign mem_data_o = mem_addr_i[15:0] ^ salt_i;
  // bus clock runs only in a cycle; strobe spans one rising and one falling edge
  always @(posedge clk_i) begin
    if (go_i) begin
      ctrl_o <= 5'b00000;
      addr_o <= start_i;
      cnt <= 4'h0;
    end else if (stop_i) begin
      ctrl_o <= 5'b01110;
    end else if (!ctrl_o.chip_en_n) begin
      cnt <= cnt + 4'h1;
      if (cnt[0]) ctrl_o.bus_clk <= !ctrl_o.bus_clk;
      if (cnt == 4'h4) begin
        ctrl_o.address_valid_n <= 1'b1;
        addr_o <= ~addr_o;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/flash_burst_read_test.sv
// self-checking bench for the flash burst read control
`timescale 1ns/1ps
`default_nettype none
module flash_burst_read_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, stop = 1'b0, live = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, dq_oe, stall, stall_oe;
  logic [23:0] start = 24'h00_0000;
  logic [15:0] salt = 16'h0000;
  logic [15:0] dq, last, md;
  logic [23:0] ma, ha;
  flash_read_pkg::flash_ctrl_t ctrl;
  logic [31:0] rq[$];
  logic [15:0] dqq[$];
  int bad_count = 0;
  int n_tests = 0;
  flash_burst_read i_flash_burst_read (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ctrl_i(ctrl), .addr_i(ha), .dq_o(dq), .dq_oe_o(dq_oe), .wait_o(stall),
    .wait_oe_o(stall_oe), .mem_addr_o(ma), .mem_data_i(md));
  flash_host_model i_flash_host_model (.clk_i, .go_i(go), .stop_i(stop), .start_i(start),
    .salt_i(salt), .mem_addr_i(ma), .ctrl_o(ctrl), .addr_o(ha), .mem_data_o(md));
  always #50 clk_i = !clk_i;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic burst(input logic [2:0] sz, input logic nw);
    flash_read_pkg::read_config_t c;
    int n, k;
    logic [23:0] s, a, m;
    logic [15:0] sl;
    c = '0;
    c.first_access_latency = 3'h3 + 3'($urandom_range(1)); // slow clock
    c.wait_polarity = 1'($urandom);
    c.data_hold_cycles = 1'($urandom); // either hold fits
    c.stall_early_release = 1'($urandom);
    c.burst_order = 1'b1; // linear
    c.clk_rising = 1'($urandom);
    c.burst_nowrap = nw;
    c.burst_size = sz;
    wb(1'b1, flash_read_pkg::CFG_OFFSET, {16'($urandom), c});
    rq.push_back({16'h0000, c});
    wb(1'b0, flash_read_pkg::CFG_OFFSET, 32'h0000_0000);
    n = sz == flash_read_pkg::SIZE_CONT ? 20 : 2 << sz;
    m = 24'(n - 1);
    s = 24'($urandom);
    sl = 16'($urandom);
    for (k = 0; k < n; k++) begin
      if (nw || sz == flash_read_pkg::SIZE_CONT) a = s + 24'(k); // up
      else a = (s & ~m) | ((s + 24'(k)) & m); // wrap
      dqq.push_back(a[15:0] ^ sl);
    end
    start <= s;
    salt <= sl;
    last = dq;
    live <= 1'b1;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    while (dqq.size() > 0 && k < 600) begin
      @(posedge clk_i);
      k++;
    end
    chk(32'(dqq.size()), 32'h0); // all words
    dqq.delete();
    if (sz != flash_read_pkg::SIZE_CONT) repeat (12) @(posedge clk_i);
    live <= 1'b0;
    stop <= 1'b1;
    @(posedge clk_i);
    stop <= 1'b0;
    repeat (3) @(posedge clk_i);
    $display("burst of %0d nowrap %0d done", n, nw);
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) chk(rdat, rq.pop_front());
    if (live && dq !== last) begin
      last = dq;
      chk({31'h0, dq_oe}, 32'h1); // driven with the word
      if (dqq.size() > 0) chk({16'h0, dq}, {16'h0, dqq.pop_front()}); // order
      else chk(32'h1, 32'h0); // no extra word
    end
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
  initial begin
    logic [2:0] sizes[4];
    sizes = '{flash_read_pkg::SIZE_4, flash_read_pkg::SIZE_8, flash_read_pkg::SIZE_16,
      flash_read_pkg::SIZE_CONT};
    void'($urandom(32'h9a0f_b2c8));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rq.push_back({16'h0000, flash_read_pkg::CFG_RESET});
    wb(1'b0, flash_read_pkg::CFG_OFFSET, 32'h0000_0000);
    rq.push_back(32'h0000_0000);
    wb(1'b0, 8'h10, 32'h0000_0000);
    start <= 24'($urandom);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk({31'h0, stall}, 32'h0); // async idle level
    chk({31'h0, stall_oe}, 32'h1); // driven
    stop <= 1'b1;
    @(posedge clk_i);
    stop <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, stall_oe}, 32'h0); // floating
    $display("register and async test done");
    for (int r = 0; r < 2; r++) begin
      foreach (sizes[i]) burst(sizes[i], 1'(r));
    end
    stop_test();
  end
endmodule
`default_nettype wire
